// >>> core/ir_mode_pkg.sv
package ir_mode_pkg;
  // Reference clock rate in kHz
  localparam int unsigned clk_khz = 20000;
  // Setup and hold of transmit data around the shutdown falling edge, in ns
  localparam int unsigned setup_ns = 200;
  localparam int unsigned hold_ns = 200;
  // Least times round up to whole cycles
  localparam int unsigned setup_cycles = (setup_ns * clk_khz + 999999) / 1000000;
  localparam int unsigned hold_cycles = (hold_ns * clk_khz + 999999) / 1000000;
  localparam int unsigned cnt_w = 8;
  localparam logic [cnt_w-1:0] setup_cnt = cnt_w'(setup_cycles);
  localparam logic [cnt_w-1:0] hold_cnt = cnt_w'(hold_cycles);
  localparam logic [cnt_w-1:0] cnt_reset = 8'h00;
  // Bandwidth codes
  localparam logic mode_slow = 1'b0;
  localparam logic mode_fast = 1'b1;
endpackage

// >>> core/ir_seq_if.sv
`timescale 1ns/1ps
// Timer handshake between the sequencer and its delay counter
interface ir_seq_if;
  logic start;
  logic [ir_mode_pkg::cnt_w-1:0] load;
  logic done;
  modport seq (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface

// >>> core/ir_delay_timer.sv
`timescale 1ns/1ps
module ir_delay_timer (
  input wire logic ref_clk,
  input wire logic rst_n,
  ir_seq_if.tmr tif
);
  typedef struct packed {
    logic [ir_mode_pkg::cnt_w-1:0] cnt;
    logic busy;
    logic done;
  } tmr_s;
  tmr_s r;
  tmr_s next_r;

  // Count down; done pulses one cycle when the count expires
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (tif.start) begin
      next_r.cnt = tif.load;
      next_r.busy = 1'b1;
    end else if (r.busy) begin
      if (r.cnt <= 8'h01) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tif.done = r.done;
endmodule

// >>> core/ir_rate_mode_latch.sv
`timescale 1ns/1ps
// How it works
// - Leave static mode pin undriven when unused or in standby.
// - Mode changes without the static pin happen only via our sequence.
// - Fast: raise shutdown, raise transmit data, wait 200 ns, drop shutdown.
// - Fast: hold transmit data high 200 ns after edge, then drop it.
// - Slow: shutdown high, data low, wait 200 ns, drop, hold low 200 ns.
module ir_rate_mode_latch (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic prog_req,
  input wire logic prog_fast,
  input wire logic static_en,
  input wire logic static_fast,
  input wire logic standby,
  input wire logic tx_data,
  output logic shutdown_mode_select,
  output logic transmit_drive_input,
  output logic mode_pin_out,
  output logic mode_pin_oe,
  output logic busy,
  output logic mode_valid,
  output logic mode_fast,
  output logic rx_active
);
  typedef enum logic [2:0] {
    st_unset,
    st_raise,
    st_setup,
    st_hold,
    st_ready,
    st_standby
  } seq_e;

  typedef struct packed {
    seq_e st;
    logic target;
    logic sd;
    logic txd;
    logic pin_out;
    logic pin_oe;
    logic busy;
    logic valid;
    logic fast;
    logic rx;
    logic start;
    logic [ir_mode_pkg::cnt_w-1:0] load;
  } ctl_s;

  ctl_s r;
  ctl_s next_r;
  ir_seq_if tif ();

  // Delay counter for setup and hold windows
  ir_delay_timer u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tif(tif)
  );

  assign tif.start = r.start;
  assign tif.load = r.load;

  // Sequencer; static pin drive runs beside it
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.busy = 1'b0;
    // pin float: drive only when static mode wanted and not in standby
    next_r.pin_oe = static_en && !standby;
    next_r.pin_out = static_fast ? ir_mode_pkg::mode_fast : ir_mode_pkg::mode_slow;
    unique case (r.st)
      // no default mode: stay unset until programmed or static
      st_unset: begin
        next_r.sd = 1'b0;
        next_r.txd = 1'b0;
        next_r.valid = static_en;
        next_r.fast = static_fast;
        if (standby) begin
          next_r.st = st_standby;
        end else if (prog_req && !static_en) begin
          next_r.target = prog_fast;
          next_r.st = st_raise;
        end
      end
      // mode change without the static pin only through this sequence
      st_raise: begin
        next_r.busy = 1'b1;
        next_r.sd = 1'b1;
        next_r.valid = 1'b0;
        // data level set while shutdown high
        next_r.txd = r.target;
        next_r.start = 1'b1;
        next_r.load = ir_mode_pkg::setup_cnt;
        next_r.st = st_setup;
      end
      st_setup: begin
        next_r.busy = 1'b1;
        if (tif.done) begin
          // falling edge latches data level in the transceiver
          next_r.sd = 1'b0;
          next_r.start = 1'b1;
          next_r.load = ir_mode_pkg::hold_cnt;
          next_r.st = st_hold;
        end
      end
      st_hold: begin
        next_r.busy = 1'b1;
        if (tif.done) begin
          next_r.txd = 1'b0;
          next_r.valid = 1'b1;
          next_r.fast = r.target;
          next_r.st = st_ready;
        end
      end
      // data pin now carries ordinary transmit data
      st_ready: begin
        next_r.sd = 1'b0;
        next_r.txd = tx_data;
        if (static_en) begin
          next_r.fast = static_fast;
        end
        if (standby) begin
          next_r.txd = 1'b0;
          next_r.st = st_standby;
        end else if (prog_req && !static_en) begin
          next_r.txd = 1'b0;
          next_r.target = prog_fast;
          next_r.st = st_raise;
        end
      end
      // Shutdown loses the mode; a fresh sequence or the static pin is needed on wake
      st_standby: begin
        next_r.sd = 1'b1;
        next_r.txd = 1'b0;
        next_r.valid = 1'b0;
        if (!standby) begin
          next_r.sd = 1'b0;
          next_r.st = st_unset;
        end
      end
      default: next_r.st = st_unset;
    endcase
    next_r.rx = !next_r.sd && next_r.valid;
    // fast flag tells upper logic which rates apply
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign shutdown_mode_select = r.sd;
  assign transmit_drive_input = r.txd;
  assign mode_pin_out = r.pin_out;
  assign mode_pin_oe = r.pin_oe;
  assign busy = r.busy;
  assign mode_valid = r.valid;
  assign mode_fast = r.fast;
  assign rx_active = r.rx;
endmodule

// >>> sim/ir_mode_props.sv
`timescale 1ns/1ps
module ir_mode_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic prog_req,
  input wire logic static_en,
  input wire logic standby,
  input wire logic shutdown_mode_select,
  input wire logic transmit_drive_input,
  input wire logic mode_pin_oe,
  input wire logic busy,
  input wire logic mode_valid,
  input wire logic mode_fast,
  input wire logic rx_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  setup_window_a:
    assert property ($fell(shutdown_mode_select) && busy |-> $past(shutdown_mode_select, 4)
      && $past(transmit_drive_input, 4) == transmit_drive_input) else $error("setup short");
  hold_window_a:
    assert property ($fell(shutdown_mode_select) && busy |=> $stable(transmit_drive_input)[*3])
      else $error("hold short");
  pin_float_a:
    assert property (!static_en || standby |=> !mode_pin_oe) else $error("pin driven");
  seq_cause_a:
    assert property ($rose(busy) |-> $past(prog_req, 2) && !$past(static_en, 2)
      && !$past(standby, 2)) else $error("unrequested sequence");
  // Mode shows six cycles after the edge: hold window of four plus timer and state latency
  mode_latch_a:
    assert property ($fell(shutdown_mode_select) && busy |-> ##6 (mode_valid
      && mode_fast == $past(transmit_drive_input, 6))) else $error("mode not latched");
  rx_quiet_a:
    assert property (shutdown_mode_select |-> !rx_active) else $error("rx on in shutdown");
endmodule
bind ir_rate_mode_latch ir_mode_props u_ir_mode_props (.ref_clk, .rst_n, .prog_req,
  .static_en, .standby, .shutdown_mode_select, .transmit_drive_input, .mode_pin_oe, .busy,
  .mode_valid, .mode_fast, .rx_active);

// >>> sim/ir_dev_model.sv
`timescale 1ns/1ps
module ir_dev_model (
  input wire logic sd,
  input wire logic txd,
  input wire logic pin_oe,
  input wire logic pin_val,
  output logic known = 1'h0,
  output logic fast = 1'h0,
  output logic rx_on
);
  logic last = 1'h0;
  // Only a true high-to-low step of sd, or a driven static pin, sets a mode
  // An unknown-to-low step at start-up is no programming edge
  always @(sd) begin
    if (sd === 1'h0 && last === 1'h1) begin
      known = 1'h1;
      fast = txd;
    end
    last = sd;
  end
  always @(pin_oe or pin_val) if (pin_oe) begin
    known = 1'h1;
    fast = pin_val;
  end
  assign rx_on = !sd && known;
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'h0, rst_n = 1'h0, prog_req = 1'h0, prog_fast = 1'h0, static_en = 1'h0;
  logic static_fast = 1'h0, standby = 1'h0, tx_data = 1'h0;
  logic shutdown_mode_select, transmit_drive_input, mode_pin_out, mode_pin_oe, busy;
  logic mode_valid, mode_fast, rx_active, known, fast, rx_on;
  int mismatches = 0, compares = 0;
  // Each row: requested mode, then the mode that should be latched
  logic [1:0] rows [5] = '{2'h3, 2'h0, 2'h0, 2'h3, 2'h3};
  always #25 ref_clk = ~ref_clk;
  ir_rate_mode_latch u_ir_rate_mode_latch (.ref_clk, .rst_n, .prog_req, .prog_fast,
    .static_en, .static_fast, .standby, .tx_data, .shutdown_mode_select,
    .transmit_drive_input, .mode_pin_out, .mode_pin_oe, .busy, .mode_valid, .mode_fast,
    .rx_active);
  ir_dev_model u_ir_dev_model (.sd(shutdown_mode_select), .txd(transmit_drive_input),
    .pin_oe(mode_pin_oe), .pin_val(mode_pin_out), .known, .fast, .rx_on);
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request, then wait for the sequence to end
  // Busy is still low when the request is taken, so wait for a settled, valid mode
  task automatic prog(input logic f, input logic e);
    @(posedge ref_clk) prog_req <= 1'h1;
    prog_fast <= f;
    @(posedge ref_clk) prog_req <= 1'h0;
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      if (busy === 1'h0 && mode_valid === 1'h1) break;
    end
    chk({mode_valid, mode_fast, known, fast}, {1'h1, e, 1'h1, e});
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    #1 chk({shutdown_mode_select, mode_pin_oe, mode_valid, known}, 4'h0);
    foreach (rows[i]) prog(rows[i][1], rows[i][0]);
    @(posedge ref_clk) tx_data <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1 chk({1'h0, transmit_drive_input, rx_on, rx_active}, 4'h7);
    // Static pin blocks a pending request
    @(posedge ref_clk) static_en <= 1'h1;
    prog_req <= 1'h1;
    prog_fast <= 1'h0;
    repeat (8) @(posedge ref_clk);
    #1 chk({busy, mode_pin_oe, mode_pin_out, fast}, 4'h4);
    // Static pin high must reach both the pin and the reported mode
    @(posedge ref_clk) static_fast <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1 chk({mode_pin_oe, mode_pin_out, fast, mode_fast}, 4'hF);
    @(posedge ref_clk) prog_req <= 1'h0;
    standby <= 1'h1;
    repeat (3) @(posedge ref_clk);
    #1 chk({mode_pin_oe, shutdown_mode_select, mode_valid, rx_on}, 4'h4);
    @(posedge ref_clk) standby <= 1'h0;
    static_en <= 1'h0;
    prog(1'h0, 1'h0);
    // Reset in mid-run drops everything, then a fresh sequence works
    @(posedge ref_clk) rst_n <= 1'h0;
    #1 chk({shutdown_mode_select, busy, mode_valid, rx_active}, 4'h0);
    @(posedge ref_clk) rst_n <= 1'h1;
    prog(1'h1, 1'h1);
    wrap_up();
  end
  initial begin
    #150000;
    mismatches++;
    wrap_up();
  end
endmodule
